// ---- key_derive_params.svh ----
// Constants for the enclave key request derivation block.
`ifndef KEY_DERIVE_PARAMS_SVH
`define KEY_DERIVE_PARAMS_SVH

`define LEAF_KEY_RETRIEVAL  32'h0000_0004
`define OFS_LEAF_SELECT     8'h00
`define OFS_ISSUE           8'h04
`define OFS_REQUEST_PTR     8'h08
`define OFS_OUTPUT_PTR      8'h0C
`define OFS_STATUS          8'h10
`define OFS_FLAGS           8'h14
`define OFS_KEY_TYPE        8'h18
`define OFS_REQ_PLAT_VER    8'h1C
`define OFS_REQ_SW_VER      8'h20
`define OFS_ATTR_MASK       8'h24
`define OFS_KEY_IDENT       8'h28
`define OFS_POLICY          8'h2C
`define OFS_KEY_W0          8'h30
`define REQ_ALIGN_MASK      32'h0000_007F
`define OUT_ALIGN_MASK      32'h0000_000F
`define KEY_LAUNCH          4'h0
`define KEY_PROVISION       4'h1
`define KEY_PROV_SEAL       4'h2
`define KEY_REPORT          4'h3
`define KEY_SEAL            4'h4
`define ATTR_LAUNCH_BIT     5
`define ATTR_PROVISION_BIT  4
`define ERR_UNAUTHORIZED    32'h0000_0001
`define ERR_PLAT_VERSION    32'h0000_0002
`define ERR_SW_VERSION      32'h0000_0003
`define ERR_UNSUPPORTED     32'h0000_0004
`define FIELD_WORDS         7'h0C
`define PAD_WORDS           7'h58
`define PAD_LOW_WORD        32'hFFFF_0100
`define PAD_FILL_WORD       32'hFFFF_FFFF
`define PAD_PREFIX          160'h2004000501020403650148866009060D30313000
`define PAD_PREFIX_IDX      7'h53

`endif

// ---- key_derive_pkg.sv ----
// Types for the enclave key request derivation block.
package key_derive_pkg;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CHECK = 2'b01,
		ST_MIX   = 2'b10,
		ST_OUT   = 2'b11
	} phase_e;

	typedef struct packed {
		phase_e       phase;
		logic [31:0]  leaf;
		logic [31:0]  req_ptr;
		logic [31:0]  out_ptr;
		logic [31:0]  status;
		logic [5:0]   arith_flags;
		logic         gp_fault;
		logic [3:0]   key_type;
		logic [31:0]  req_plat_ver;
		logic [15:0]  req_sw_ver;
		logic [31:0]  attr_mask;
		logic [31:0]  key_ident;
		logic [1:0]   policy;
		logic [6:0]   idx;
		logic [127:0] acc;
		logic [127:0] key;
		logic         key_wr;
		logic         fault_pulse;
		logic [31:0]  rdata;
	} state_s;

endpackage

// ---- enclave_key_request_derivation.sv ----
// Key retrieval leaf: request checks, derivation data assembly and key output.
`timescale 1ns/10ps
`include "key_derive_params.svh"

module enclave_key_request_derivation
	import key_derive_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [7:0]   addr,
	input  wire logic [31:0]  wdata,
	input  wire logic         wr_stb,
	input  wire logic         rd_stb,
	output logic [31:0]       rdata,
	input  wire logic         in_enclave,
	input  wire logic [31:0]  encl_attr,
	input  wire logic [31:0]  encl_misc,
	input  wire logic [15:0]  encl_sw_version,
	input  wire logic [31:0]  plat_version,
	input  wire logic [31:0]  encl_meas,
	input  wire logic [31:0]  signer_meas,
	input  wire logic [31:0]  owner_epoch,
	input  wire logic [15:0]  product_id,
	input  wire logic [31:0]  random_word,
	input  wire logic [127:0] device_secret,
	output logic              key_wr_valid,
	output logic [31:0]       key_wr_addr,
	output logic [127:0]      key_wr_data,
	output logic              gp_fault_pulse,
	output logic              busy
);

	state_s s_q;
	state_s s_d;

	// Key type values the hardware knows.
	function automatic logic supported(input logic [3:0] t);
		supported = (t == `KEY_LAUNCH) || (t == `KEY_PROVISION) ||
			(t == `KEY_PROV_SEAL) || (t == `KEY_REPORT) || (t == `KEY_SEAL);
	endfunction

	// Word i of the fixed padding constant, lowest word first.
	function automatic logic [31:0] pad_word(input logic [6:0] i);
		logic [159:0] pre;
		logic [6:0]   k;
		pre = `PAD_PREFIX;
		k = i - `PAD_PREFIX_IDX;
		if (i == 7'h00) begin
			pad_word = `PAD_LOW_WORD;
		end else if (i < `PAD_PREFIX_IDX) begin
			pad_word = `PAD_FILL_WORD;
		end else begin
			pad_word = pre[{k[2:0], 5'b00000} +: 32];
		end
	endfunction

	// Stand-in mixing step; the real primitive is outside this block.
	function automatic logic [127:0] mix(input logic [127:0] a, input logic [31:0] w);
		logic [127:0] r;
		r = {a[114:0], a[127:115]};
		mix = r ^ {a[31:0] ^ w, ~w, w, a[127:96] ^ {w[15:0], w[31:16]}};
	endfunction

	logic        uses_req;
	logic        is_report;
	logic        is_prov;
	logic        include_epoch;
	logic        authorized;
	logic        need_pad;
	logic [31:0] field;
	logic [31:0] req_attr;
	logic [6:0]  last_idx;

	// Derivation field selection per key type.
	always_comb begin
		is_report = (s_q.key_type == `KEY_REPORT);
		is_prov = (s_q.key_type == `KEY_PROVISION) || (s_q.key_type == `KEY_PROV_SEAL);
		uses_req = !is_report;
		include_epoch = (s_q.key_type != `KEY_PROVISION);
		need_pad = is_report;
		last_idx = need_pad ? (`FIELD_WORDS + `PAD_WORDS - 7'h01) : (`FIELD_WORDS - 7'h01);
		req_attr = s_q.attr_mask & encl_attr;
		case (s_q.key_type)
			`KEY_LAUNCH: authorized = encl_attr[`ATTR_LAUNCH_BIT];
			`KEY_PROVISION: authorized = encl_attr[`ATTR_PROVISION_BIT];
			`KEY_PROV_SEAL: authorized = encl_attr[`ATTR_PROVISION_BIT];
			default: authorized = 1'b1;
		endcase
		field = 32'h0000_0000;
		case (s_q.idx)
			7'h00: field = {28'h0000000, s_q.key_type};
			7'h01: field = uses_req ? req_attr : encl_attr;
			7'h02: field = encl_misc;
			7'h03: field = include_epoch ? owner_epoch : 32'h0000_0000;
			7'h04: field = uses_req ? s_q.req_plat_ver : plat_version;
			7'h05: field = uses_req ? {16'h0000, s_q.req_sw_ver} : 32'h0000_0000;
			7'h06: field = is_report ? 32'h0000_0000 : {16'h0000, product_id};
			7'h07: begin
				if (is_report) begin
					field = encl_meas;
				end else if (s_q.key_type == `KEY_SEAL && s_q.policy[0]) begin
					field = encl_meas;
				end else begin
					field = 32'h0000_0000;
				end
			end
			7'h08: begin
				if (is_prov) begin
					field = signer_meas;
				end else if (s_q.key_type == `KEY_SEAL && s_q.policy[1]) begin
					field = signer_meas;
				end else begin
					field = 32'h0000_0000;
				end
			end
			7'h09: field = is_prov ? random_word : s_q.key_ident;
			7'h0A: field = uses_req ? s_q.attr_mask : 32'h0000_0000;
			7'h0B: field = s_q.leaf;
			default: field = pad_word(s_q.idx - `FIELD_WORDS);
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.key_wr = 1'b0;
		s_d.fault_pulse = 1'b0;
		s_d.rdata = 32'h0000_0000;

		// Request fields may only change while no request is in flight.
		if (wr_stb && s_q.phase == ST_IDLE) begin
			case (addr)
				`OFS_LEAF_SELECT: s_d.leaf = wdata;
				`OFS_REQUEST_PTR: s_d.req_ptr = wdata;
				`OFS_OUTPUT_PTR: s_d.out_ptr = wdata;
				`OFS_KEY_TYPE: s_d.key_type = wdata[3:0];
				`OFS_REQ_PLAT_VER: s_d.req_plat_ver = wdata;
				`OFS_REQ_SW_VER: s_d.req_sw_ver = wdata[15:0];
				`OFS_ATTR_MASK: s_d.attr_mask = wdata;
				`OFS_KEY_IDENT: s_d.key_ident = wdata;
				`OFS_POLICY: s_d.policy = wdata[1:0];
				`OFS_ISSUE: begin
					if (s_q.leaf == `LEAF_KEY_RETRIEVAL) begin
						if (!in_enclave) begin
							s_d.gp_fault = 1'b1;
							s_d.fault_pulse = 1'b1;
						end else if ((s_q.req_ptr & `REQ_ALIGN_MASK) != 32'h0000_0000 ||
							(s_q.out_ptr & `OUT_ALIGN_MASK) != 32'h0000_0000) begin
							s_d.gp_fault = 1'b1;
							s_d.fault_pulse = 1'b1;
						end else begin
							s_d.gp_fault = 1'b0;
							s_d.phase = ST_CHECK;
						end
					end
				end
				default: begin
				end
			endcase
		end

		if (rd_stb) begin
			case (addr)
				`OFS_LEAF_SELECT: s_d.rdata = s_q.leaf;
				`OFS_REQUEST_PTR: s_d.rdata = s_q.req_ptr;
				`OFS_OUTPUT_PTR: s_d.rdata = s_q.out_ptr;
				`OFS_STATUS: s_d.rdata = s_q.status;
				`OFS_FLAGS: s_d.rdata = {24'h000000, s_q.phase != ST_IDLE, s_q.gp_fault,
					s_q.arith_flags};
				`OFS_KEY_TYPE: s_d.rdata = {28'h0000000, s_q.key_type};
				`OFS_REQ_PLAT_VER: s_d.rdata = s_q.req_plat_ver;
				`OFS_REQ_SW_VER: s_d.rdata = {16'h0000, s_q.req_sw_ver};
				`OFS_ATTR_MASK: s_d.rdata = s_q.attr_mask;
				`OFS_KEY_IDENT: s_d.rdata = s_q.key_ident;
				`OFS_POLICY: s_d.rdata = {30'h00000000, s_q.policy};
				`OFS_KEY_W0: s_d.rdata = s_q.key[31:0];
				`OFS_KEY_W0 + 8'h04: s_d.rdata = s_q.key[63:32];
				`OFS_KEY_W0 + 8'h08: s_d.rdata = s_q.key[95:64];
				`OFS_KEY_W0 + 8'h0C: s_d.rdata = s_q.key[127:96];
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end

		case (s_q.phase)
			ST_IDLE: begin
			end
			ST_CHECK: begin
				// Fixed order; only the first failing check is reported.
				s_d.phase = ST_IDLE;
				s_d.arith_flags = 6'b000001;
				if (!supported(s_q.key_type)) begin
					s_d.status = `ERR_UNSUPPORTED;
				end else if (!authorized) begin
					s_d.status = `ERR_UNAUTHORIZED;
				end else if (uses_req && s_q.req_plat_ver > plat_version) begin
					s_d.status = `ERR_PLAT_VERSION;
				end else if (uses_req && s_q.req_sw_ver > encl_sw_version) begin
					s_d.status = `ERR_SW_VERSION;
				end else begin
					s_d.arith_flags = 6'b000000;
					s_d.phase = ST_MIX;
					s_d.idx = 7'h00;
					s_d.acc = device_secret;
				end
			end
			ST_MIX: begin
				s_d.acc = mix(s_q.acc, field);
				s_d.idx = s_q.idx + 7'h01;
				if (s_q.idx == last_idx) begin
					s_d.phase = ST_OUT;
				end
			end
			ST_OUT: begin
				s_d.key = s_q.acc;
				s_d.key_wr = 1'b1;
				s_d.status = 32'h0000_0000;
				s_d.arith_flags = 6'b000000;
				s_d.phase = ST_IDLE;
			end
			default: s_d.phase = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Zero flag sits in bit 0; the other five flags follow it.
	assign rdata = s_q.rdata;
	assign key_wr_valid = s_q.key_wr;
	assign key_wr_addr = s_q.out_ptr;
	assign key_wr_data = s_q.key;
	assign gp_fault_pulse = s_q.fault_pulse;
	assign busy = (s_q.phase != ST_IDLE);

endmodule

// ---- key_derive_props.sv ----
// Port assertions for the key request derivation block.
`timescale 1ns/10ps
`include "key_derive_params.svh"
module key_derive_props (
	input wire logic         clk,
	input wire logic         rst,
	input wire logic [7:0]   addr,
	input wire logic         wr_stb,
	input wire logic         in_enclave,
	input wire logic         key_wr_valid,
	input wire logic [31:0]  key_wr_addr,
	input wire logic [127:0] key_wr_data,
	input wire logic         gp_fault_pulse,
	input wire logic         busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_fault_no_key: assert property (
		gp_fault_pulse |-> !key_wr_valid && !busy) else $error("fault came with key or busy");
	chk_fault_single: assert property (
		gp_fault_pulse |=> !gp_fault_pulse) else $error("fault pulse too long");
	chk_key_single: assert property (
		key_wr_valid |=> !key_wr_valid) else $error("key pulse too long");
	chk_key_ends_busy: assert property (
		key_wr_valid |-> !busy && $past(busy)) else $error("key write not at end of busy");
	chk_issue_starts: assert property (
		$rose(busy) |-> $past(wr_stb) && $past(addr) == `OFS_ISSUE) else $error("busy without issue");
	chk_busy_bounded: assert property (
		$rose(busy) |-> ##[1:110] !busy) else $error("busy too long");
	chk_key_aligned: assert property (
		key_wr_valid |-> key_wr_addr[3:0] == 4'h0) else $error("key written misaligned");
	chk_key_held: assert property (
		!key_wr_valid |-> $stable(key_wr_data)) else $error("key data moved without write");
	chk_key_inside: assert property (
		key_wr_valid |-> in_enclave) else $error("key produced outside enclave");
	chk_start_inside: assert property (
		$rose(busy) |-> in_enclave) else $error("request started outside enclave");
endmodule
bind enclave_key_request_derivation key_derive_props u_key_derive_props (.clk, .rst, .addr,
	.wr_stb, .in_enclave, .key_wr_valid, .key_wr_addr, .key_wr_data, .gp_fault_pulse, .busy);

// ---- enclave_sw.sv ----
// Bus master model of the enclave software issuing key requests.
`timescale 1ns/10ps
`include "key_derive_params.svh"
module enclave_sw (
	input  wire logic        clk,
	input  wire logic [31:0] rdata,
	output logic [7:0]       addr = 8'h00,
	output logic [31:0]      wdata = 32'h0,
	output logic             wr_stb = 1'b0,
	output logic             rd_stb = 1'b0
);
	// A released bus shows the inverse of its last value, so stale data never looks valid.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask
	// Callers pass aligned in-enclave pointers unless a fault is wanted.
	task automatic load(input logic [31:0] rq, input logic [31:0] op);
		wr(`OFS_REQUEST_PTR, rq);
		wr(`OFS_OUTPUT_PTR, op);
	endtask
endmodule

// ---- enclave_key_request_derivation_tb.sv ----
// Self-checking bench for the key request derivation block.
`timescale 1ns/10ps
`include "key_derive_params.svh"
module enclave_key_request_derivation_tb;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic [7:0]   addr;
	logic [31:0]  wdata, rdata, encl_attr, encl_misc, plat_version, encl_meas, signer_meas;
	logic [31:0]  owner_epoch, random_word, key_wr_addr, optr, rptr, st;
	logic [15:0]  encl_sw_version, product_id;
	logic [127:0] device_secret, key_wr_data, kq, k2;
	logic         wr_stb, rd_stb, key_wr_valid, gp_fault_pulse, busy;
	logic         in_enclave = 1'b1;
	logic [31:0]  seed = 32'h8A414216;
	int           errors = 0;
	int           n_checks = 0;
	always #25 clk = ~clk;
	enclave_sw u_enclave_sw (.clk, .rdata, .addr, .wdata, .wr_stb, .rd_stb);
	enclave_key_request_derivation u_enclave_key_request_derivation (.clk, .rst, .addr, .wdata,
		.wr_stb, .rd_stb, .rdata, .in_enclave, .encl_attr, .encl_misc, .encl_sw_version,
		.plat_version, .encl_meas, .signer_meas, .owner_epoch, .product_id, .random_word,
		.device_secret, .key_wr_valid, .key_wr_addr, .key_wr_data, .gp_fault_pulse, .busy);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Bit f: enclave measurement, signer, owner epoch, product id, misc selection feed type t.
	function automatic logic incl(input int t, input int f);
		logic [4:0] m [5] = '{5'h1C, 5'h1A, 5'h1E, 5'h15, 5'h1F};
		return m[t][f];
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Latency lat counts edges after the issue edge up to the key pulse; 0 means no key, -1 a fault.
	task automatic run(input logic [3:0] kt, input logic [31:0] es, input int lat);
		logic [31:0] d;
		int          hit;
		u_enclave_sw.wr(`OFS_KEY_TYPE, {28'h0, kt});
		u_enclave_sw.wr(`OFS_ISSUE, 32'h1);
		hit = 0;
		// Step 0 looks just after the issue edge, where a fault pulse stands for one cycle.
		for (int i = 0; i <= 110; i++) begin
			if (i > 0) begin
				@(posedge clk);
			end
			#1;
			if (key_wr_valid === 1'b1) begin
				hit = (hit == 0) ? i : 999;
				kq = key_wr_data;
				cmp(key_wr_addr, optr);
			end
			if (gp_fault_pulse === 1'b1) hit = -1;
		end
		cmp(hit, lat);
		u_enclave_sw.rd(`OFS_STATUS, d);
		cmp(d, es);
		u_enclave_sw.rd(`OFS_FLAGS, d);
		cmp(d & 32'h3F, (lat > 0) ? 32'h0 : 32'h1);
		for (int w = 0; w < 4 && lat > 0; w++) begin
			u_enclave_sw.rd(8'(`OFS_KEY_W0 + 4 * w), d);
			cmp(d, kq[32 * w +: 32]);
		end
	endtask
	initial begin
		encl_attr = rnd() | 32'h30;
		encl_misc = rnd();
		encl_sw_version = 16'(rnd());
		plat_version = rnd();
		encl_meas = rnd();
		signer_meas = rnd();
		owner_epoch = rnd();
		product_id = 16'(rnd());
		random_word = rnd();
		device_secret = {rnd(), rnd(), rnd(), rnd()};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		optr = rnd() & ~32'hF;
		rptr = rnd() & ~32'h7F;
		u_enclave_sw.wr(`OFS_LEAF_SELECT, `LEAF_KEY_RETRIEVAL);
		u_enclave_sw.load(rptr, optr);
		u_enclave_sw.wr(`OFS_REQ_PLAT_VER, plat_version);
		u_enclave_sw.wr(`OFS_REQ_SW_VER, {16'h0, encl_sw_version});
		u_enclave_sw.wr(`OFS_ATTR_MASK, rnd());
		u_enclave_sw.wr(`OFS_KEY_IDENT, rnd());
		u_enclave_sw.wr(`OFS_POLICY, 32'h3);
		for (int t = 0; t < 5; t++) begin
			run(4'(t), 32'h0, (t == 3) ? 102 : 14);
			k2 = kq;
			for (int f = 0; f < 5; f++) begin
				st = rnd() | 32'h1;
				case (f)
					0: encl_meas <= encl_meas ^ st;
					1: signer_meas <= signer_meas ^ st;
					2: owner_epoch <= owner_epoch ^ st;
					3: product_id <= product_id ^ st[15:0];
					default: encl_misc <= encl_misc ^ st;
				endcase
				run(4'(t), 32'h0, (t == 3) ? 102 : 14);
				cmp(32'(kq !== k2), 32'(incl(t, f)));
				k2 = kq;
			end
		end
		run(4'h5, `ERR_UNSUPPORTED, 0);
		run(4'hF, `ERR_UNSUPPORTED, 0);
		encl_attr <= encl_attr & ~32'h20;
		run(`KEY_LAUNCH, `ERR_UNAUTHORIZED, 0);
		encl_attr <= (encl_attr | 32'h20) & ~32'h10;
		run(`KEY_PROVISION, `ERR_UNAUTHORIZED, 0);
		run(`KEY_PROV_SEAL, `ERR_UNAUTHORIZED, 0);
		encl_attr <= encl_attr | 32'h30;
		u_enclave_sw.wr(`OFS_REQ_PLAT_VER, plat_version + 32'h1);
		run(`KEY_SEAL, `ERR_PLAT_VERSION, 0);
		u_enclave_sw.wr(`OFS_REQ_PLAT_VER, plat_version);
		u_enclave_sw.wr(`OFS_REQ_SW_VER, {16'h0, encl_sw_version + 16'h1});
		run(`KEY_SEAL, `ERR_SW_VERSION, 0);
		u_enclave_sw.wr(`OFS_REQ_SW_VER, {16'h0, encl_sw_version});
		in_enclave <= 1'b0;
		run(`KEY_SEAL, `ERR_SW_VERSION, -1);
		in_enclave <= 1'b1;
		u_enclave_sw.load(rptr | 32'h40, optr);
		run(`KEY_SEAL, `ERR_SW_VERSION, -1);
		u_enclave_sw.load(rptr, optr | 32'h8);
		run(`KEY_SEAL, `ERR_SW_VERSION, -1);
		u_enclave_sw.load(rptr, optr);
		u_enclave_sw.wr(`OFS_LEAF_SELECT, 32'h5);
		run(`KEY_SEAL, `ERR_SW_VERSION, 0);
		complete_run();
	end
	initial begin
		#2000000;
		errors++;
		complete_run();
	end
endmodule
